// ### src/pam_pkg.sv
// package of constants and types for the protection, alarm and event monitor
package pam_pkg;

	localparam int unsigned meas_w = 16;

	// register byte offsets
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] status_off = 8'h04;
	localparam logic [7:0] ack_off = 8'h08;
	localparam logic [7:0] vprot_thr_off = 8'h0c;
	localparam logic [7:0] iprot_thr_off = 8'h10;
	localparam logic [7:0] pprot_thr_off = 8'h14;
	localparam logic [7:0] evt_thr_base = 8'h18;
	localparam logic [7:0] evt_act_off = 8'h2c;
	localparam logic [7:0] rated_v_off = 8'h30;
	localparam logic [7:0] rated_i_off = 8'h34;
	localparam logic [7:0] rated_p_off = 8'h38;

	// control field positions
	localparam int unsigned ctrl_out_req_bit = 0;
	localparam int unsigned ctrl_sound_bit = 1;
	localparam int unsigned ctrl_temp_auto_bit = 2;
	localparam int unsigned ctrl_supply_auto_bit = 3;

	// status and acknowledge field positions (same layout)
	localparam int unsigned st_vprot_bit = 0;
	localparam int unsigned st_iprot_bit = 1;
	localparam int unsigned st_pprot_bit = 2;
	localparam int unsigned st_supply_bit = 3;
	localparam int unsigned st_temp_bit = 4;
	localparam int unsigned st_evt_lsb = 8;
	localparam int unsigned st_out_on_bit = 16;
	localparam int unsigned st_blocked_bit = 17;

	localparam int unsigned num_evt = 5;
	localparam int unsigned evt_low_v = 0;
	localparam int unsigned evt_high_v = 1;
	localparam int unsigned evt_low_i = 2;
	localparam int unsigned evt_high_i = 3;
	localparam int unsigned evt_high_p = 4;

	// rated values and reset values
	localparam logic [meas_w-1:0] rated_v_rst = 16'h8000;
	localparam logic [meas_w-1:0] rated_i_rst = 16'h8000;
	localparam logic [meas_w-1:0] rated_p_rst = 16'h8000;
	// protection default is 110 percent of rating
	localparam int unsigned prot_pct = 110;
	localparam logic [31:0] ctrl_rst = 32'h0000_0000;

	typedef enum logic [1:0] {
		pam_act_none = 2'b00,
		pam_act_signal = 2'b01,
		pam_act_warning = 2'b10,
		pam_act_alarm = 2'b11
	} pam_action_t;

	typedef enum logic [1:0] {
		pam_rd_idle = 2'b00,
		pam_rd_resp = 2'b01
	} pam_rd_state_t;

	localparam logic [1:0] axi_okay = 2'b00;
	localparam logic [1:0] axi_slverr = 2'b10;

endpackage : pam_pkg

// ### src/pam_monitor.sv
// protection, alarm and event monitor with an axi4-lite register slave
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps

module pam_monitor
	import pam_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [meas_w-1:0] meas_voltage,
	input wire logic [meas_w-1:0] meas_current,
	input wire logic [meas_w-1:0] meas_power,
	input wire logic supply_fail,
	input wire logic over_temp,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic dc_output_on,
	output logic acoustic_out,
	output logic warning_out
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		pam_rd_state_t rd_state;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic [31:0] ctrl;
		logic [meas_w-1:0] vprot_thr;
		logic [meas_w-1:0] iprot_thr;
		logic [meas_w-1:0] pprot_thr;
		logic [num_evt-1:0][meas_w-1:0] evt_thr;
		logic [num_evt-1:0][1:0] evt_act;
		logic [meas_w-1:0] rated_v;
		logic [meas_w-1:0] rated_i;
		logic [meas_w-1:0] rated_p;
		logic vprot_flag;
		logic iprot_flag;
		logic pprot_flag;
		logic supply_flag;
		logic temp_flag;
		logic [num_evt-1:0] evt_flag;
		logic [num_evt-1:0] evt_cause;
		logic out_on;
		logic resume_pending;
		logic acoustic;
		logic warning;
		// ready flags live here so the bus sees them from a flop, gated only by clk_en
		logic aw_rdy;
		logic w_rdy;
		logic ar_rdy;
	} pam_state_t;

	pam_state_t s_q;
	pam_state_t s_d;

	// ************************************************************
	// helper functions
	// ************************************************************
	// default threshold saturates rather than wrapping when the rating is near full scale

	function automatic logic [meas_w-1:0] pct_of(input logic [meas_w-1:0] rated);
		logic [meas_w+7:0] prod;
		prod = (meas_w+8)'(rated) * (meas_w+8)'(prot_pct);
		pct_of = (prod / (meas_w+8)'(100)) > (meas_w+8)'({meas_w{1'b1}}) ?
			{meas_w{1'b1}} : meas_w'(prod / (meas_w+8)'(100));
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// ************************************************************
	// combinational next state
	// ************************************************************
	logic vprot_cause;
	logic iprot_cause;
	logic pprot_cause;
	logic s_axi_awready_c;
	logic s_axi_wready_c;
	logic s_axi_arready_c;
	logic [num_evt-1:0] evt_hit;
	logic [num_evt-1:0] evt_trig;
	logic [num_evt-1:0] evt_alarm;
	logic [num_evt-1:0] evt_ack;
	logic [num_evt-1:0] evt_reg_hit;
	logic wr_fire;
	logic blocked;
	logic trip;
	logic [31:0] wd;
	logic [31:0] ack_bits;
	logic [31:0] status_word;

	always_comb begin
		s_d = s_q;

		// ************************************************************
		// measurement compares
		// ************************************************************
		// protection trips at the threshold itself, events only beyond it
		vprot_cause = (meas_voltage >= s_q.vprot_thr);
		iprot_cause = (meas_current >= s_q.iprot_thr);
		pprot_cause = (meas_power >= s_q.pprot_thr);
		evt_hit[evt_low_v] = (meas_voltage < s_q.evt_thr[evt_low_v]);
		evt_hit[evt_high_v] = (meas_voltage > s_q.evt_thr[evt_high_v]);
		evt_hit[evt_low_i] = (meas_current < s_q.evt_thr[evt_low_i]);
		evt_hit[evt_high_i] = (meas_current > s_q.evt_thr[evt_high_i]);
		evt_hit[evt_high_p] = (meas_power > s_q.evt_thr[evt_high_p]);
		evt_trig = '0;
		evt_alarm = '0;
		evt_ack = '0;
		evt_reg_hit = '0;
		for (int e = 0; e < num_evt; e++) begin
			// each event has its own threshold and action; none means disabled
			evt_trig[e] = s_q.out_on && evt_hit[e] && (s_q.evt_act[e] != pam_act_none);
			evt_alarm[e] = evt_trig[e] && (s_q.evt_act[e] == pam_act_alarm);
		end


		// ************************************************************
		// write channel: address and data taken in either order
		// ************************************************************
		// take only what the master saw offered, i.e. the registered ready
		s_axi_awready_c = s_q.aw_rdy;
		s_axi_wready_c = s_q.w_rdy;
		if (s_axi_awvalid && s_axi_awready_c) begin
			s_d.aw_full = 1'b1;
			s_d.aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready_c) begin
			s_d.w_full = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		wr_fire = s_q.aw_full && s_q.w_full && !s_q.b_valid;
		wd = s_q.w_data;
		ack_bits = '0;
		if (wr_fire) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.b_valid = 1'b1;
			s_d.b_resp = axi_okay;
			// whole event configuration lives in these registers, so a profile load rewrites it all
			unique case (s_q.aw_addr)
				ctrl_off: s_d.ctrl = merge(s_q.ctrl, wd, s_q.w_strb);
				ack_off: ack_bits = wd & {32{s_q.w_strb[0] | s_q.w_strb[1]}};
				vprot_thr_off: s_d.vprot_thr = meas_w'(merge(32'(s_q.vprot_thr), wd, s_q.w_strb));
				iprot_thr_off: s_d.iprot_thr = meas_w'(merge(32'(s_q.iprot_thr), wd, s_q.w_strb));
				pprot_thr_off: s_d.pprot_thr = meas_w'(merge(32'(s_q.pprot_thr), wd, s_q.w_strb));
				evt_act_off: begin
					for (int e = 0; e < num_evt; e++) begin
						if (s_q.w_strb[(2*e)/8]) begin
							s_d.evt_act[e] = wd[2*e +: 2];
						end
					end
				end
				rated_v_off: s_d.rated_v = meas_w'(merge(32'(s_q.rated_v), wd, s_q.w_strb));
				rated_i_off: s_d.rated_i = meas_w'(merge(32'(s_q.rated_i), wd, s_q.w_strb));
				rated_p_off: s_d.rated_p = meas_w'(merge(32'(s_q.rated_p), wd, s_q.w_strb));
				status_off: s_d.b_resp = axi_okay;
				default: begin
					s_d.b_resp = axi_slverr;
					for (int e = 0; e < num_evt; e++) begin
						if (s_q.aw_addr == evt_thr_base + 8'(4*e)) begin
							evt_reg_hit[e] = 1'b1;
							s_d.evt_thr[e] = meas_w'(merge(32'(s_q.evt_thr[e]), wd, s_q.w_strb));
							s_d.b_resp = axi_okay;
						end
					end
				end
			endcase
		end
		if (s_q.b_valid && s_axi_bready) begin
			s_d.b_valid = 1'b0;
		end


		// ************************************************************
		// alarm flags: set wins over acknowledge; ack only when cause gone
		// ************************************************************
		s_d.vprot_flag = vprot_cause | (s_q.vprot_flag & ~ack_bits[st_vprot_bit]);
		s_d.iprot_flag = iprot_cause | (s_q.iprot_flag & ~ack_bits[st_iprot_bit]);
		s_d.pprot_flag = pprot_cause | (s_q.pprot_flag & ~ack_bits[st_pprot_bit]);
		s_d.supply_flag = supply_fail | (s_q.supply_flag & ~ack_bits[st_supply_bit]);
		s_d.temp_flag = over_temp | (s_q.temp_flag & ~ack_bits[st_temp_bit]);
		for (int e = 0; e < num_evt; e++) begin
			evt_ack[e] = ack_bits[st_evt_lsb + e] && !evt_hit[e];
			s_d.evt_flag[e] = evt_trig[e] | (s_q.evt_flag[e] & ~evt_ack[e]);
			// alarm-action events remember their cause so they block until acknowledged
			s_d.evt_cause[e] = evt_alarm[e] | (s_q.evt_cause[e] & ~evt_ack[e]);
		end


		// ************************************************************
		// dc output control
		// ************************************************************
		// protection and alarm-action event flags block until acknowledged
		blocked = s_q.vprot_flag | s_q.iprot_flag | s_q.pprot_flag | (|s_q.evt_cause);
		trip = vprot_cause | iprot_cause | pprot_cause | supply_fail | over_temp | (|evt_alarm);
		// a software write of the request bit cancels a pending restore, but a restore firing in the same cycle still sets the bit
		if (wr_fire && s_q.aw_addr == ctrl_off && s_q.w_strb[0]) begin
			s_d.resume_pending = 1'b0;
		end
		if (supply_fail && s_q.out_on && s_q.ctrl[ctrl_supply_auto_bit]) begin
			s_d.resume_pending = 1'b1;
		end
		if (over_temp && s_q.out_on && s_q.ctrl[ctrl_temp_auto_bit]) begin
			s_d.resume_pending = 1'b1;
		end
		if (trip) begin
			s_d.out_on = 1'b0;
		end else if (blocked) begin
			s_d.out_on = 1'b0;
		end else if (s_q.resume_pending && !s_q.ctrl[ctrl_out_req_bit]) begin
			// automatic restore of the state before the hardware alarm
			s_d.out_on = 1'b1;
			s_d.resume_pending = 1'b0;
			s_d.ctrl[ctrl_out_req_bit] = 1'b1;
		end else begin
			s_d.out_on = s_q.ctrl[ctrl_out_req_bit];
		end
		// any trip drops the software request so the output stays off until reasked or automatically restored
		if (trip) begin
			s_d.ctrl[ctrl_out_req_bit] = 1'b0;
		end


		// ************************************************************
		// indications
		// ************************************************************
		s_d.acoustic = s_q.ctrl[ctrl_sound_bit] && (s_q.vprot_flag | s_q.iprot_flag | s_q.pprot_flag
			| s_q.supply_flag | s_q.temp_flag | (|s_q.evt_cause));
		// alarm-action events sound instead; warning covers signal and warning actions only
		s_d.warning = |(s_q.evt_flag & ~s_q.evt_cause);


		// ************************************************************
		// read channel
		// ************************************************************
		status_word = '0;
		status_word[st_vprot_bit] = s_q.vprot_flag;
		status_word[st_iprot_bit] = s_q.iprot_flag;
		status_word[st_pprot_bit] = s_q.pprot_flag;
		status_word[st_supply_bit] = s_q.supply_flag;
		status_word[st_temp_bit] = s_q.temp_flag;
		status_word[st_evt_lsb +: num_evt] = s_q.evt_flag;
		status_word[st_out_on_bit] = s_q.out_on;
		status_word[st_blocked_bit] = blocked;
		s_axi_arready_c = s_q.ar_rdy;
		unique case (s_q.rd_state)
			pam_rd_idle: begin
				if (s_axi_arvalid && s_axi_arready_c) begin
					s_d.rd_state = pam_rd_resp;
					s_d.r_resp = axi_okay;
					s_d.r_data = '0;
					unique case (s_axi_araddr[7:0])
						ctrl_off: s_d.r_data = s_q.ctrl;
						status_off: s_d.r_data = status_word;
						ack_off: s_d.r_data = '0;
						vprot_thr_off: s_d.r_data = 32'(s_q.vprot_thr);
						iprot_thr_off: s_d.r_data = 32'(s_q.iprot_thr);
						pprot_thr_off: s_d.r_data = 32'(s_q.pprot_thr);
						evt_act_off: s_d.r_data = 32'(s_q.evt_act);
						rated_v_off: s_d.r_data = 32'(s_q.rated_v);
						rated_i_off: s_d.r_data = 32'(s_q.rated_i);
						rated_p_off: s_d.r_data = 32'(s_q.rated_p);
						default: begin
							s_d.r_resp = axi_slverr;
							for (int e = 0; e < num_evt; e++) begin
								if (s_axi_araddr[7:0] == evt_thr_base + 8'(4*e)) begin
									s_d.r_data = 32'(s_q.evt_thr[e]);
									s_d.r_resp = axi_okay;
								end
							end
						end
					endcase
				end
			end
			pam_rd_resp: begin
				if (s_axi_rready) begin
					s_d.rd_state = pam_rd_idle;
				end
			end
			// the two spare codes fall back to idle
			default: s_d.rd_state = pam_rd_idle;
		endcase

		// next ready follows the next free state, so ready never offers a slot that is held
		s_d.aw_rdy = !s_d.aw_full && !s_d.b_valid;
		s_d.w_rdy = !s_d.w_full && !s_d.b_valid;
		s_d.ar_rdy = (s_d.rd_state == pam_rd_idle);
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ctrl <= ctrl_rst;
			s_q.rated_v <= rated_v_rst;
			s_q.rated_i <= rated_i_rst;
			s_q.rated_p <= rated_p_rst;
			// readys stay low in reset and rise one edge after release
			s_q.vprot_thr <= pct_of(rated_v_rst);
			s_q.iprot_thr <= pct_of(rated_i_rst);
			s_q.pprot_thr <= pct_of(rated_p_rst);
			s_q.evt_act <= '0;
			s_q.rd_state <= pam_rd_idle;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// limitation: readys are gated by the enable, since a frozen edge must never complete a transfer
	assign s_axi_awready = s_q.aw_rdy & clk_en;
	assign s_axi_wready = s_q.w_rdy & clk_en;
	assign s_axi_arready = s_q.ar_rdy & clk_en;
	assign s_axi_bvalid = s_q.b_valid;
	assign s_axi_bresp = s_q.b_resp;
	assign s_axi_rvalid = (s_q.rd_state == pam_rd_resp);
	assign s_axi_rdata = s_q.r_data;
	assign s_axi_rresp = s_q.r_resp;
	assign dc_output_on = s_q.out_on;
	assign acoustic_out = s_q.acoustic;
	assign warning_out = s_q.warning;

endmodule // pam_monitor

// ### verif/pam_power_stage.sv
// model of the power stage measurement front end feeding the monitor
`timescale 1ns/1ps
module pam_power_stage
	import pam_pkg::*;
(
	input wire logic aclk,
	input wire logic [meas_w-1:0] v_tgt,
	input wire logic [meas_w-1:0] i_tgt,
	input wire logic [meas_w-1:0] p_tgt,
	output logic [meas_w-1:0] meas_voltage,
	output logic [meas_w-1:0] meas_current,
	output logic [meas_w-1:0] meas_power
);
	// converters settle one cycle after the operating point moves; the switch state is not
	// modelled, so the terminal level stays visible with the output off, as a slow decay would
	always_ff @(posedge aclk) begin
		meas_voltage <= v_tgt;
		meas_current <= i_tgt;
		meas_power <= p_tgt;
	end
endmodule // pam_power_stage

// ### verif/pam_monitor_properties.sv
// concurrent assertions on the ports of the protection and alarm monitor
`timescale 1ns/1ps
module pam_monitor_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic supply_fail,
	input wire logic over_temp,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dc_output_on
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ****
	// handshake sequences
	// ****
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// ****
	// properties
	// ****
	a_supply_trip_off: assert property (supply_fail [*3] |-> !dc_output_on)
		else $error("output on during supply failure");
	a_temp_trip_off: assert property (over_temp [*3] |-> !dc_output_on)
		else $error("output on during over temperature");
	a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_bresp_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_freeze_ready: assert property (!clk_en |-> !(s_axi_awready || s_axi_wready || s_axi_arready))
		else $error("ready while frozen");
	a_freeze_output: assert property (!clk_en |=> $stable(dc_output_on))
		else $error("output moved while frozen");
	a_pending_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
endmodule // pam_monitor_props

bind pam_monitor pam_monitor_props i_props (.*);

// ### verif/pam_monitor_test.sv
// self-checking testbench for the protection, alarm and event monitor
`timescale 1ns/1ps
module pam_monitor_test;
	import pam_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic clk_en = 1'b1;
	logic supply_fail = 1'b0;
	logic over_temp = 1'b0;
	logic [meas_w-1:0] v_tgt = 16'h4000, i_tgt = 16'h4000, p_tgt = 16'h4000;
	logic [meas_w-1:0] meas_voltage, meas_current, meas_power;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic dc_output_on, acoustic_out, warning_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
	logic [31:0] rng = 32'h0000_32ef;
	logic [31:0] rd_val, thr;
	int err_count = 0;
	int check_count = 0;
	always #4 aclk = ~aclk;
	pam_power_stage i_stage (.*);
	pam_monitor i_dut (.*);
	// ****
	// helpers
	// ****
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [31:0] prot_default(input logic [meas_w-1:0] r);
		return (32'(r) * 110) / 100;
	endfunction
	function automatic logic [31:0] bitv(input int b);
		return 32'h0000_0001 << b;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic set_meas(input int k, input logic [meas_w-1:0] v);
		if (k == 0) v_tgt <= v;
		else if (k == 1) i_tgt <= v;
		else p_tgt <= v;
	endtask
	// handshakes are judged on the rising edge, with the values the slave sampled there
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw_t, w_t, b_t;
		n = 0;
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			aw_t = s_axi_awvalid & s_axi_awready;
			w_t = s_axi_wvalid & s_axi_wready;
			b_t = s_axi_bvalid & s_axi_bready;
			if (b_t) wr_resp = s_axi_bresp;
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			n++;
		end while (!b_t && n < 100);
		s_axi_bready <= 1'b0;
		if (!b_t) err_count++;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		logic a_t, r_t;
		n = 0;
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			a_t = s_axi_arvalid & s_axi_arready;
			r_t = s_axi_rvalid & s_axi_rready;
			if (r_t) begin
				rd_val = s_axi_rdata;
				rd_resp = s_axi_rresp;
			end
			if (a_t) s_axi_arvalid <= 1'b0;
			n++;
		end while (!r_t && n < 100);
		s_axi_rready <= 1'b0;
		if (!r_t) err_count++;
		@(posedge aclk);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		cyc(5);
		aresetn <= 1'b1;
		cyc(2);
		for (int k = 0; k < 3; k++) begin
			rd(vprot_thr_off + 8'(4 * k));
			chk(rd_val, prot_default(k == 0 ? rated_v_rst : k == 1 ? rated_i_rst : rated_p_rst));
		end
		rd(evt_act_off);
		chk(rd_val, 32'h0000_0000);
		rd(8'h40);
		chk({rd_val[29:0], rd_resp}, 32'(axi_slverr));
		wr(8'h40, 32'h0000_0000);
		chk(32'(wr_resp), 32'(axi_slverr));
		clk_en <= 1'b0;
		cyc(3);
		clk_en <= 1'b1;
		// voltage, current, power protection; sound enabled except on the current pass
		for (int k = 0; k < 3; k++) begin
			wr(ctrl_off, (k == 1) ? bitv(0) : 32'h0000_0003);
			cyc(4);
			chk(32'(dc_output_on), 32'h0000_0001);
			thr = prot_default(rated_v_rst);
			set_meas(k, thr[15:0]);
			cyc(4);
			chk({dc_output_on, acoustic_out}, {1'b0, k != 1});
			rd(status_off);
			chk(rd_val & 32'h0002_001f, bitv(k) | bitv(st_blocked_bit));
			wr(ack_off, bitv(k));
			rd(status_off);
			chk(rd_val & 32'h0000_001f, bitv(k));
			set_meas(k, 16'h4000);
			cyc(4);
			wr(ctrl_off, bitv(0));
			cyc(4);
			chk(32'(dc_output_on), 32'h0000_0000);
			wr(ack_off, bitv(k));
			rd(status_off);
			chk(rd_val & 32'h0002_001f, 32'h0000_0000);
		end
		// supply failure with auto restore, then over temperature without
		for (int k = 0; k < 2; k++) begin
			wr(ctrl_off, (k == 0) ? 32'h0000_0009 : bitv(0));
			cyc(4);
			if (k == 0) supply_fail <= 1'b1;
			else over_temp <= 1'b1;
			cyc(4);
			chk(32'(dc_output_on), 32'h0000_0000);
			supply_fail <= 1'b0;
			over_temp <= 1'b0;
			cyc(4);
			chk(32'(dc_output_on), 32'(k == 0));
			wr(ctrl_off, bitv(0));
			cyc(4);
			chk(32'(dc_output_on), 32'h0000_0001);
			rd(status_off);
			chk(rd_val & 32'h0000_0018, bitv(st_supply_bit + k));
			wr(ctrl_off, 32'h0000_0000);
			wr(ack_off, bitv(st_supply_bit + k));
		end
		// one user event at a time; actions cycle through none, signal, warning, alarm
		for (int e = 0; e < num_evt; e++) begin
			rng = next_rand(rng);
			thr = 32'h0000_1000 + (rng & 32'h0000_5fff);
			wr(evt_thr_base + 8'(4 * e), thr);
			wr(evt_act_off, 32'(e % 4) << (2 * e));
			set_meas(e / 2, (e == 0 || e == 2) ? thr[15:0] - 16'h0001 : thr[15:0] + 16'h0001);
			cyc(4);
			rd(status_off);
			chk(rd_val & 32'h0000_1f00, 32'h0000_0000);
			set_meas(e / 2, thr[15:0]);
			wr(ctrl_off, bitv(0));
			cyc(4);
			rd(status_off);
			chk(rd_val & 32'h0000_1f00, 32'h0000_0000);
			set_meas(e / 2, (e == 0 || e == 2) ? thr[15:0] - 16'h0001 : thr[15:0] + 16'h0001);
			cyc(4);
			rd(status_off);
			chk({rd_val[st_evt_lsb + e], dc_output_on, warning_out}, {e % 4 != 0, e % 4 != 3, e % 4 == 1 || e % 4 == 2});
			wr(ctrl_off, 32'h0000_0000);
			// park exactly on the threshold so the cause is gone and the acknowledge is taken
			set_meas(e / 2, thr[15:0]);
			cyc(4);
			wr(ack_off, bitv(st_evt_lsb + e));
		end
		summarize;
	end
	initial begin
		cyc(20000);
		err_count++;
		summarize;
	end
endmodule // pam_monitor_test
